/* gas_pkg.sv */
// constants, codes and register map of the serial setpoint command handler
// assumes a byte-wide serial receiver and transmitter outside this block
package gas_pkg;
  localparam logic [7:0] START_CMD = 8'h21;
  localparam logic [7:0] START_RSP = 8'h2A;
  localparam logic [7:0] CMD_SET_ADDR = 8'h38;
  localparam logic [7:0] CMD_SET_OFS = 8'h39;
  localparam int NUM_TRIP = 6;
  // index 0/1: relay 1 high/low, 2/3: relay 2, 4/5: relay 3
  localparam logic [7:0] RD_CODE [NUM_TRIP] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B};
  localparam logic [7:0] WR_CODE [NUM_TRIP] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
  localparam logic [3:0] LEN_SHORT = 4'h5;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam logic [3:0] LEN_NONE = 4'h0;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_OFS = 8'h0C;
  localparam logic [7:0] REG_TRIP0 = 8'h10;
  localparam logic [7:0] REG_TRIP5 = 8'h24;
  localparam logic [7:0] REG_COUNT = 8'h28;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [7:0] OFS_RST = 8'h00;
  localparam logic [31:0] TRIP_RST = 32'h00000000;
  localparam logic [1:0] CTRL_RST = 2'h3;
  // longest gap between two bytes of one command
  localparam int CLK_HZ = 25000000;
  localparam int GAP_TIME_US = 10000;
  localparam int GAP_CYC = GAP_TIME_US * (CLK_HZ / 1000000);

  typedef struct packed {
    logic hit;
    logic wr;
    logic [2:0] idx;
  } gas_trip_t;

  // expected message length for a command code, LEN_NONE if unknown
  function automatic logic [3:0] msg_len(input logic [7:0] cmd);
    logic [3:0] len;
    len = LEN_NONE;
    if (cmd == CMD_SET_ADDR || cmd == CMD_SET_OFS) len = LEN_SHORT;
    for (int i = 0; i < NUM_TRIP; i++) begin
      if (cmd == RD_CODE[i] || cmd == WR_CODE[i]) len = LEN_LONG;
    end
    return len;
  endfunction

  function automatic gas_trip_t trip_decode(input logic [7:0] cmd);
    gas_trip_t t;
    t = '0;
    for (int i = 0; i < NUM_TRIP; i++) begin
      if (cmd == RD_CODE[i]) t = '{1'b1, 1'b0, 3'(i)};
      if (cmd == WR_CODE[i]) t = '{1'b1, 1'b1, 3'(i)};
    end
    return t;
  endfunction
endpackage

/* gas_rx.sv */
// command frame collector: finds '!', gathers bytes, checks length and checksum
// assumes rx_valid pulses one cycle per received byte
`timescale 1ns/100ps
module gas_rx
  import gas_pkg::*;
#(
  parameter int GAP_LIMIT = gas_pkg::GAP_CYC
) (
  input wire logic sys_clk, // clock
  input wire logic srst, // sync reset
  input wire logic chk_en, // checksum check on
  input wire logic [7:0] rx_data, // received byte
  input wire logic rx_valid, // byte strobe
  output logic frm_valid, // good frame pulse
  output logic frm_drop, // dropped frame pulse
  output logic [7:0] frm_addr, // leading byte
  output logic [7:0] frm_cmd, // command code
  output logic [31:0] frm_data // payload, first byte highest
);
  typedef enum logic {RX_IDLE, RX_RECV} gas_rx_t;
  gas_rx_t state_ff;
  logic [3:0] cnt_ff;
  logic [3:0] len_ff;
  logic [7:0] sum_ff;
  logic [17:0] gap_ff;

  always_ff @(posedge sys_clk) begin
    frm_valid <= 1'b0;
    frm_drop <= 1'b0;
    if (srst) begin
      state_ff <= RX_IDLE;
      cnt_ff <= 4'h0;
      len_ff <= LEN_NONE;
      sum_ff <= 8'h00;
      gap_ff <= 18'h00000;
      frm_addr <= 8'h00;
      frm_cmd <= 8'h00;
      frm_data <= 32'h00000000;
    end else if (state_ff == RX_IDLE) begin
      if (rx_valid && rx_data == START_CMD) begin
        state_ff <= RX_RECV;
        cnt_ff <= 4'h1;
        sum_ff <= 8'h00;
        gap_ff <= 18'h00000;
        frm_data <= 32'h00000000;
      end
    end else if (!rx_valid) begin
      gap_ff <= gap_ff + 18'h00001;
      if (gap_ff >= 18'(GAP_LIMIT - 1)) begin
        state_ff <= RX_IDLE;
        frm_drop <= 1'b1;
      end
    end else begin
      gap_ff <= 18'h00000;
      cnt_ff <= cnt_ff + 4'h1;
      sum_ff <= sum_ff + rx_data;
      if (cnt_ff == 4'h1) begin
        frm_addr <= rx_data;
      end else if (cnt_ff == 4'h2) begin
        frm_cmd <= rx_data;
        len_ff <= msg_len(rx_data);
        if (msg_len(rx_data) == LEN_NONE) begin
          state_ff <= RX_IDLE;
          frm_drop <= 1'b1;
        end
      end else if (cnt_ff == len_ff - 4'h1) begin
        state_ff <= RX_IDLE;
        if (!chk_en || rx_data == sum_ff) frm_valid <= 1'b1;
        else frm_drop <= 1'b1;
      end else begin
        frm_data <= {frm_data[23:0], rx_data};
      end
    end
  end
endmodule

/* gas_tx.sv */
// reply framer: sends '*', leading byte, code, payload and checksum
// assumes the byte sink holds tx_ready low while it cannot take a byte
`timescale 1ns/100ps
module gas_tx
  import gas_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic srst, // sync reset
  input wire logic start, // begin reply, ignored while busy
  input wire logic [3:0] len, // reply length in bytes
  input wire logic [7:0] addr, // leading byte
  input wire logic [7:0] cmd, // command code
  input wire logic [31:0] data, // payload, short reply in low byte
  input wire logic tx_ready, // sink takes byte
  output logic [7:0] tx_data, // byte out
  output logic tx_valid, // byte valid
  output logic busy // reply in progress
);
  logic [3:0] idx_ff;
  logic [3:0] len_ff;
  logic [7:0] sum_ff;
  logic [7:0] addr_ff;
  logic [7:0] cmd_ff;
  logic [31:0] pay_ff;
  logic [7:0] nxt_byte;

  always_comb begin
    nxt_byte = pay_ff[31:24];
    if (idx_ff == 4'h1) nxt_byte = addr_ff;
    else if (idx_ff == 4'h2) nxt_byte = cmd_ff;
    else if (idx_ff == len_ff - 4'h1) nxt_byte = sum_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idx_ff <= 4'h0;
      len_ff <= LEN_SHORT;
      sum_ff <= 8'h00;
      addr_ff <= 8'h00;
      cmd_ff <= 8'h00;
      pay_ff <= 32'h00000000;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      busy <= 1'b0;
    end else if (!busy) begin
      if (start) begin
        tx_data <= START_RSP;
        tx_valid <= 1'b1;
        busy <= 1'b1;
        idx_ff <= 4'h1;
        len_ff <= len;
        sum_ff <= 8'h00;
        addr_ff <= addr;
        cmd_ff <= cmd;
        pay_ff <= (len == LEN_LONG) ? data : {data[7:0], 24'h000000};
      end
    end else if (tx_ready) begin
      if (idx_ff == len_ff) begin
        tx_valid <= 1'b0;
        busy <= 1'b0;
      end else begin
        tx_data <= nxt_byte;
        idx_ff <= idx_ff + 4'h1;
        if (idx_ff != len_ff - 4'h1) sum_ff <= sum_ff + nxt_byte;
        if (idx_ff > 4'h2) pay_ff <= {pay_ff[23:0], 8'h00};
      end
    end
  end
endmodule

/* gas_top.sv */
// serial setpoint and address command handler with an apb register window
// assumes an external uart delivering and taking whole bytes on sys_clk
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module gas_top
#(
  parameter int GAP_LIMIT = gas_pkg::GAP_CYC,
  parameter int NUM_TRIP = gas_pkg::NUM_TRIP
) (
  input wire logic sys_clk, // 25 mhz clock
  input wire logic srst, // sync reset, high
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [7:0] rx_data, // received byte
  input wire logic rx_valid, // received byte strobe
  output logic [7:0] tx_data, // reply byte
  output logic tx_valid, // reply byte valid
  input wire logic tx_ready, // reply sink ready
  output logic [7:0] unit_addr, // unit address
  output logic [7:0] addr_offset, // unit address offset
  output logic [32*NUM_TRIP-1:0] trip_value // trip points, index 0 in low word
);
  import gas_pkg::*;

  logic frm_valid;
  logic frm_drop;
  logic [7:0] frm_addr;
  logic [7:0] frm_cmd;
  logic [31:0] frm_data;
  logic tx_busy;
  logic [7:0] tx_byte;
  logic tx_vld;

  logic [1:0] ctrl_ff;
  logic [7:0] addr_ff;
  logic [7:0] ofs_ff;
  logic [31:0] trip_ff [NUM_TRIP];
  logic [15:0] good_cnt_ff;
  logic [15:0] drop_cnt_ff;
  logic [7:0] last_cmd_ff;
  logic over_ff;

  logic rsp_start_ff;
  logic [3:0] rsp_len_ff;
  logic [7:0] rsp_addr_ff;
  logic [7:0] rsp_cmd_ff;
  logic [31:0] rsp_data_ff;

  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  logic cmd_en;
  logic frm_take;
  logic frm_ignored;
  gas_trip_t trip_sel;
  logic apb_access;
  logic apb_wr;
  logic apb_mapped;
  logic [2:0] apb_trip_idx;
  logic apb_trip_hit;
  logic [31:0] nxt_rdata;
  logic cnt_clr;

  // decoded strobes
  logic apb_first_access;
  logic wr_ctrl;
  logic wr_status;
  logic wr_addr;
  logic wr_ofs;
  logic ser_set_addr;
  logic ser_set_ofs;
  logic ser_trip_wr;
  logic rsp_slot_free;
  logic [NUM_TRIP-1:0] trip_wr_ser;
  logic [NUM_TRIP-1:0] trip_wr_apb;

  gas_rx #(
    .GAP_LIMIT(GAP_LIMIT)
  ) u_rx (
    .sys_clk(sys_clk),
    .srst(srst),
    .chk_en(ctrl_ff[1]),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .frm_valid(frm_valid),
    .frm_drop(frm_drop),
    .frm_addr(frm_addr),
    .frm_cmd(frm_cmd),
    .frm_data(frm_data)
  );

  gas_tx u_tx (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(rsp_start_ff),
    .len(rsp_len_ff),
    .addr(rsp_addr_ff),
    .cmd(rsp_cmd_ff),
    .data(rsp_data_ff),
    .tx_ready(tx_ready),
    .tx_data(tx_byte),
    .tx_valid(tx_vld),
    .busy(tx_busy)
  );

  // frame acceptance: enabled, addressed to this unit
  always_comb begin
    cmd_en = ctrl_ff[0];
    frm_take = frm_valid && cmd_en && (frm_addr == addr_ff);
    frm_ignored = frm_valid && !frm_take;
    trip_sel = trip_decode(frm_cmd);
  end

  // serial commands that change stored state
  always_comb begin
    ser_set_addr = frm_take && frm_cmd == CMD_SET_ADDR;
    ser_set_ofs = frm_take && frm_cmd == CMD_SET_OFS;
    ser_trip_wr = frm_take && trip_sel.hit && trip_sel.wr;
    rsp_slot_free = !tx_busy && !rsp_start_ff;
  end

  // apb decode
  always_comb begin
    apb_access = psel && penable && pready_ff;
    apb_wr = apb_access && pwrite && !pslverr_ff;
    apb_trip_hit = (paddr >= REG_TRIP0) && (paddr <= REG_TRIP5) && (paddr[1:0] == 2'h0);
    apb_trip_idx = 3'((paddr - REG_TRIP0) >> 2);
    apb_mapped = apb_trip_hit || paddr == REG_CTRL || paddr == REG_STATUS
      || paddr == REG_ADDR || paddr == REG_OFS || paddr == REG_COUNT;
    cnt_clr = apb_wr && paddr == REG_COUNT;
    apb_first_access = psel && penable && !pready_ff;
  end

  // per-register write strobes, live only at the pready edge of a mapped write
  always_comb begin
    wr_ctrl = apb_wr && paddr == REG_CTRL;
    wr_status = apb_wr && paddr == REG_STATUS;
    wr_addr = apb_wr && paddr == REG_ADDR;
    wr_ofs = apb_wr && paddr == REG_OFS;
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (apb_trip_hit) begin
      nxt_rdata = trip_ff[apb_trip_idx];
    end else begin
      unique case (paddr)
        REG_CTRL: nxt_rdata = {30'h00000000, ctrl_ff};
        REG_STATUS: nxt_rdata = {22'h000000, last_cmd_ff, over_ff, tx_busy};
        REG_ADDR: nxt_rdata = {24'h000000, addr_ff};
        REG_OFS: nxt_rdata = {24'h000000, ofs_ff};
        REG_COUNT: nxt_rdata = {drop_cnt_ff, good_cnt_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // apb handshake: one wait state after the first access cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= apb_first_access;
    end
  end

  // error flag stands with pready only, raised for an unmapped address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= apb_first_access && !apb_mapped;
    end
  end

  // read data captured in the wait cycle; writes read back zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata_ff <= 32'h00000000;
    end else if (apb_first_access) begin
      prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  // unit address; a serial command wins over a bus write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_ff <= ADDR_RST;
    end else if (ser_set_addr) begin
      addr_ff <= frm_data[7:0];
    end else if (wr_addr) begin
      addr_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ofs_ff <= OFS_RST;
    end else if (ser_set_ofs) begin
      ofs_ff <= frm_data[7:0];
    end else if (wr_ofs) begin
      ofs_ff <= pwdata[7:0];
    end
  end

  // trip point storage, one word per relay edge
  generate
    for (genvar i = 0; i < NUM_TRIP; i++) begin : g_trip
      assign trip_wr_ser[i] = ser_trip_wr && trip_sel.idx == 3'(i);
      assign trip_wr_apb[i] = apb_wr && apb_trip_hit && apb_trip_idx == 3'(i);
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          trip_ff[i] <= TRIP_RST;
        end else if (trip_wr_ser[i]) begin
          trip_ff[i] <= frm_data;
        end else if (trip_wr_apb[i]) begin
          trip_ff[i] <= pwdata;
        end
      end
    end
  endgenerate

  // reply start pulse; while the framer is busy the reply is dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp_start_ff <= 1'b0;
    end else begin
      rsp_start_ff <= frm_take && rsp_slot_free;
    end
  end

  // reply contents, latched with the start pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp_len_ff <= LEN_SHORT;
      rsp_addr_ff <= 8'h00;
      rsp_cmd_ff <= 8'h00;
      rsp_data_ff <= 32'h00000000;
    end else if (frm_take && rsp_slot_free) begin
      rsp_addr_ff <= frm_addr;
      rsp_cmd_ff <= frm_cmd;
      if (trip_sel.hit) begin
        rsp_len_ff <= LEN_LONG;
        if (trip_sel.wr) rsp_data_ff <= frm_data;
        else rsp_data_ff <= trip_ff[trip_sel.idx];
      end else begin
        rsp_len_ff <= LEN_SHORT;
        rsp_data_ff <= {24'h000000, frm_data[7:0]};
      end
    end
  end

  // last accepted command
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_cmd_ff <= 8'h00;
    end else if (frm_take) begin
      last_cmd_ff <= frm_cmd;
    end
  end

  // sticky overrun, cleared by writing 1 to status bit 1; a new overrun wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      over_ff <= 1'b0;
    end else if (frm_take && !rsp_slot_free) begin
      over_ff <= 1'b1;
    end else if (wr_status && pwdata[1]) begin
      over_ff <= 1'b0;
    end
  end

  // accepted frame counter; an event in the clearing cycle counts as one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      good_cnt_ff <= 16'h0000;
    end else if (cnt_clr) begin
      good_cnt_ff <= {15'h0000, frm_take};
    end else if (frm_take) begin
      good_cnt_ff <= good_cnt_ff + 16'h0001;
    end
  end

  // dropped frame counter, same clearing rule
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      drop_cnt_ff <= 16'h0000;
    end else if (cnt_clr) begin
      drop_cnt_ff <= {15'h0000, frm_drop};
    end else if (frm_drop) begin
      drop_cnt_ff <= drop_cnt_ff + 16'h0001;
    end
  end

  // port copies of the stored state, one cycle behind
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      unit_addr <= ADDR_RST;
    end else begin
      unit_addr <= addr_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_offset <= OFS_RST;
    end else begin
      addr_offset <= ofs_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trip_value <= '0;
    end else begin
      for (int i = 0; i < NUM_TRIP; i++) begin
        trip_value[32*i +: 32] <= trip_ff[i];
      end
    end
  end

  // flop outputs straight to the ports
  always_comb begin
    prdata = prdata_ff;
    pready = pready_ff;
    pslverr = pslverr_ff;
    tx_data = tx_byte;
    tx_valid = tx_vld;
  end

  logic unused_ignored;
  assign unused_ignored = frm_ignored;
endmodule

/* gas_assertions.sv */
// checker of the apb window and reply framing of the command handler
// assumes it is bound to gas_top, one clock domain
`timescale 1ns/100ps
module gas_assertions #(
  parameter int GAP_LIMIT = 50,
  parameter int NUM_TRIP = 6
) (
  input wire logic sys_clk, // clock
  input wire logic srst, // reset
  input wire logic [7:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [7:0] rx_data, // rx byte
  input wire logic rx_valid, // rx strobe
  input wire logic [7:0] tx_data, // tx byte
  input wire logic tx_valid, // tx valid
  input wire logic tx_ready, // tx ready
  input wire logic [7:0] unit_addr, // address
  input wire logic [7:0] addr_offset, // offset
  input wire logic [32*NUM_TRIP-1:0] trip_value // trip words
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb wait not one cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (pready && paddr > 8'h28 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte not held");
  a_reply_star: assert property ($rose(tx_valid) |-> tx_data == 8'h2A)
    else $error("reply does not open with star");
  a_tx_drop_hs: assert property ($fell(tx_valid) |-> $past(tx_ready))
    else $error("reply byte dropped without handshake");
  a_addr_apb_write: assert property (pready && pwrite && paddr == 8'h08 && !pslverr
    |-> ##2 unit_addr == $past(pwdata[7:0], 2))
    else $error("address write lost");
  c_reply: cover property ($rose(tx_valid));
  c_stall: cover property (tx_valid && !tx_ready);
  c_err: cover property (pready && pslverr);
endmodule
bind gas_top gas_assertions #(.GAP_LIMIT(GAP_LIMIT), .NUM_TRIP(NUM_TRIP)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .unit_addr(unit_addr), .addr_offset(addr_offset),
  .trip_value(trip_value));

/* gas_host.sv */
// serial host model: sends command frames and collects reply bytes
// assumes the handler's byte ports on the same clock
`timescale 1ns/100ps
module gas_host (
  input wire logic sys_clk, // clock
  input wire logic slow, // stall reply every other cycle
  output logic [7:0] rx_data, // byte out
  output logic rx_valid, // byte strobe
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_valid, // reply valid
  output logic tx_ready // sink ready
);
  logic [7:0] got[$];
  initial begin
    rx_data = 8'hFF;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic put(input logic [7:0] b);
    @(posedge sys_clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    // idle line must not show the stale byte
    rx_data <= ~b;
  endtask
  task automatic send(input logic [7:0] lead, input logic [7:0] cmd, input logic [31:0] pl,
    input int n, input logic [7:0] bad);
    logic [7:0] cs;
    cs = lead + cmd + bad;
    put(8'h21);
    put(lead);
    put(cmd);
    for (int i = n - 1; i >= 0; i--) begin
      cs = cs + pl[8*i+:8];
      put(pl[8*i+:8]);
    end
    put(cs);
  endtask
endmodule

/* gas_top_tb.sv */
// bench of the command handler: frames, replies and apb window
// assumes gas_host on the serial side and the bound checker
`timescale 1ns/100ps
module gas_top_tb;
  localparam logic [7:0] WRC [6] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
  localparam logic [7:0] RDC [6] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B};
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, err, slow;
  logic rx_valid, tx_valid, tx_ready;
  logic [7:0] paddr, rx_data, tx_data, unit_addr, addr_offset, lead;
  logic [31:0] pwdata, prdata, rd;
  logic [191:0] trip_value;
  int fails = 0, n_tests = 0, cyc = 0;
  gas_top #(.GAP_LIMIT(50)) uut (.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .unit_addr(unit_addr),
    .addr_offset(addr_offset), .trip_value(trip_value));
  gas_host host (.sys_clk(sys_clk), .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected reply: star, command's leading byte, code, payload, sum
  task automatic reply(input logic [7:0] cmd, input logic [31:0] pl, input int n);
    logic [7:0] e[$];
    logic [7:0] cs;
    int k;
    e = {8'h2A, lead, cmd};
    cs = lead + cmd;
    for (int i = n - 1; i >= 0; i--) begin
      e.push_back(pl[8*i+:8]);
      cs = cs + pl[8*i+:8];
    end
    e.push_back(cs);
    k = 0;
    while (host.got.size() < e.size() && k < 400) begin
      @(posedge sys_clk);
      k = k + 1;
    end
    chk(32'(host.got.size()), 32'(e.size()));
    for (int i = 0; i < e.size(); i++)
      chk(32'(host.got[i]), 32'(e[i]));
    host.got.delete();
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic quiet;
    repeat (40) @(posedge sys_clk);
    chk(32'(host.got.size()), 32'h0);
  endtask
  task automatic t_defaults;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    chk(32'(addr_offset), 32'h0);
    chk(32'(|trip_value), 32'h0);
  endtask
  task automatic t_addr;
    host.send(lead, 8'h38, 32'h07, 1, 8'h00);
    reply(8'h38, 32'h07, 1);
    chk(32'(unit_addr), 32'h07);
    lead = 8'h07;
    host.send(lead, 8'h39, 32'hA5, 1, 8'h00);
    reply(8'h39, 32'hA5, 1);
    chk(32'(addr_offset), 32'hA5);
  endtask
  task automatic t_trips;
    logic [31:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 32'h3F801020 + 32'(i);
      slow <= i[0];
      host.send(lead, WRC[i], v, 4, 8'h00);
      reply(WRC[i], v, 4);
      chk(trip_value[32*i+:32], v);
      host.send(lead, RDC[i], 32'hDEADBEEF, 4, 8'h00);
      reply(RDC[i], v, 4);
    end
    slow <= 1'b0;
  endtask
  task automatic t_bad;
    host.send(lead, 8'h11, 32'h12345678, 4, 8'h01);
    quiet;
    chk(trip_value[95:64], 32'h3F801022);
    host.send(lead, 8'h38, 32'h10203040, 4, 8'h00);
    quiet;
    chk(32'(unit_addr), 32'h07);
    host.send(lead + 8'h01, 8'h39, 32'h11, 1, 8'h00);
    quiet;
    chk(32'(addr_offset), 32'hA5);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h0002000E);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h000000AC);
  endtask
  task automatic t_apb;
    apb(1'b1, 8'h08, 32'h09);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h09);
    chk(32'(unit_addr), 32'h09);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    lead = 8'h09;
    apb(1'b1, 8'h00, 32'h2);
    host.send(lead, 8'h39, 32'h3C, 1, 8'h00);
    quiet;
    chk(32'(addr_offset), 32'hA5);
    apb(1'b1, 8'h00, 32'h3);
    host.send(lead, 8'h39, 32'h3C, 1, 8'h00);
    reply(8'h39, 32'h3C, 1);
    apb(1'b1, 8'h00, 32'h1);
    host.send(lead, 8'h39, 32'h5A, 1, 8'h01);
    reply(8'h39, 32'h5A, 1);
    chk(32'(addr_offset), 32'h5A);
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    lead = 8'h01;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    t_defaults;
    t_addr;
    t_trips;
    t_bad;
    t_apb;
    end_sim;
  end
endmodule
